// file: hw/cles_regs.sv
module cles_regs (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire logic CE,
   // Host register port
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_RD,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   // Command and memory events
   input wire logic CL_CMD_START,
   input wire logic CMD_IS_RECEIVE,
   input wire logic CMD_IS_TRANSCEIVE,
   input wire logic AUTH_CMD_ACTIVE,
   input wire logic NVM_CMD_DONE,
   input wire logic NVM_CMD_FAIL,
   // Transceiver state from the sequencer
   input wire logic [2:0] TRANSCEIVER_STATE,
   input wire logic CRC_TX_PHASE,
   input wire logic TX_REQUEST,
   // Buffer side
   input wire logic HOST_BUF_WR,
   input wire logic BUF_FULL,
   input wire logic BUF_EMPTY,
   input wire logic BUF_FLUSH,
   input wire logic MULTI_FRAME_RECEIVE,
   input wire logic ERR_FLAGS_STORED,
   output logic HOST_BUF_WR_ACCEPT,
   output logic RX_PUSH,
   output logic [7:0] RX_PUSH_DATA,
   // Receiver side
   input wire cles_pkg::cles_rx_ev_s RX_EV,
   input wire logic EMD_SUPPRESS_EN,
   input wire logic COLLISION_AS_ERROR,
   output logic RECEIVE_DECODER_EN,
   output logic RECEIVE_IRQ,
   output logic FRAME_DROP,
   output cles_pkg::cles_coll_s COLLISION_POSITION_REG,
   // Error summary
   output logic SUMMARY_ERROR_IRQ
);

   // ****************************************************************
   // Event decode
   // ****************************************************************
   function automatic logic in_rx_phase(input logic [2:0] code);
      in_rx_phase = (code == cles_pkg::ST_RX_WAIT) || (code == cles_pkg::ST_WAIT_DATA) ||
                    (code == cles_pkg::ST_RECEIVE);
   endfunction

   logic [cles_pkg::NUM_FLAGS-1:0] flag_set;
   logic [cles_pkg::NUM_FLAGS-1:0] flag_clr;
   logic [cles_pkg::NUM_FLAGS-1:0] flags;
   logic [2:0] state_code;
   logic [2:0] next_state_code;
   cles_pkg::cles_rx_phase_e rx_phase;
   cles_pkg::cles_rx_phase_e next_rx_phase;
   cles_pkg::cles_coll_s next_coll;
   logic [7:0] next_rdata;
   logic rx_clear;
   logic prot_hit;
   logic coll_hit;
   logic short_hit;
   logic frame_ok;
   logic next_rx_irq;
   logic next_drop;
   logic next_push;
   logic [7:0] next_push_data;

   always_comb begin
      prot_hit = RX_EV.stop_bit_err | RX_EV.sof_err | RX_EV.byte_count_err;
      coll_hit = RX_EV.coll & ~RX_EV.coll_in_eof;
      rx_clear = (CL_CMD_START & CMD_IS_RECEIVE) |
                 (CMD_IS_TRANSCEIVE & (state_code != cles_pkg::ST_WAIT_DATA) &
                  (next_state_code == cles_pkg::ST_WAIT_DATA));
      short_hit = RX_EV.frame_end & RX_EV.sof_valid &
                  ((RX_EV.bit_count < cles_pkg::MIN_FRAME_BITS) |
                   (EMD_SUPPRESS_EN & (RX_EV.bit_count < cles_pkg::EMD_MIN_BITS)));
      frame_ok = RX_EV.frame_end & ~short_hit & (rx_phase == cles_pkg::CLES_RX_RUN);
   end

   // ****************************************************************
   // Flag set and clear terms
   // ****************************************************************
   always_comb begin
      flag_set = '0;
      flag_clr = '0;
      flag_set[cles_pkg::BIT_NVM_CMD] = NVM_CMD_DONE & NVM_CMD_FAIL;
      flag_clr[cles_pkg::BIT_NVM_CMD] = NVM_CMD_DONE & ~NVM_CMD_FAIL;
      flag_set[cles_pkg::BIT_WR_MISUSE] = HOST_BUF_WR &
         (CRC_TX_PHASE | in_rx_phase(state_code) | AUTH_CMD_ACTIVE);
      flag_clr[cles_pkg::BIT_WR_MISUSE] = MULTI_FRAME_RECEIVE ? ERR_FLAGS_STORED
                                                              : CL_CMD_START;
      flag_set[cles_pkg::BIT_OVERFLOW] = (HOST_BUF_WR | RX_EV.byte_valid) & BUF_FULL;
      flag_clr[cles_pkg::BIT_OVERFLOW] = BUF_FLUSH;
      flag_set[cles_pkg::BIT_SHORT_FRAME] = short_hit;
      flag_clr[cles_pkg::BIT_SHORT_FRAME] = rx_clear;
      flag_set[cles_pkg::BIT_EMPTY_TX] = TX_REQUEST & BUF_EMPTY;
      flag_clr[cles_pkg::BIT_EMPTY_TX] = CL_CMD_START;
      flag_set[cles_pkg::BIT_COLLISION] = coll_hit;
      flag_clr[cles_pkg::BIT_COLLISION] = rx_clear;
      flag_set[cles_pkg::BIT_PROTOCOL] = prot_hit;
      flag_clr[cles_pkg::BIT_PROTOCOL] = rx_clear;
      flag_set[cles_pkg::BIT_INTEGRITY] = RX_EV.parity_err | RX_EV.crc_err |
                                          (COLLISION_AS_ERROR & coll_hit);
      flag_clr[cles_pkg::BIT_INTEGRITY] = rx_clear;
   end

   genvar gi;
   generate
      for (gi = 0; gi < cles_pkg::NUM_FLAGS; gi++) begin : g_flag
         cles_flag u_flag (
            .clk(SYS_CLK),
            .resetn(RESETN),
            .ce(CE),
            .set(flag_set[gi]),
            .clr(flag_clr[gi]),
            .q(flags[gi])
         );
      end
   endgenerate

   // ****************************************************************
   // Receive phase, state code and collision position
   // ****************************************************************
   always_comb begin
      next_rx_phase = rx_phase;
      case (rx_phase)
         cles_pkg::CLES_RX_RUN: begin
            if (prot_hit) begin
               next_rx_phase = cles_pkg::CLES_RX_HALT;
            end
         end
         cles_pkg::CLES_RX_HALT: begin
            if (CL_CMD_START | rx_clear) begin
               next_rx_phase = cles_pkg::CLES_RX_RUN;
            end
         end
         default: begin
            next_rx_phase = cles_pkg::CLES_RX_RUN;
         end
      endcase
      // The unused code is never taken over, the last legal one stays
      next_state_code = (TRANSCEIVER_STATE == cles_pkg::ST_UNUSED) ? state_code
                                                                   : TRANSCEIVER_STATE;
      next_coll = COLLISION_POSITION_REG;
      if (rx_clear) begin
         next_coll = '0;
      end else if (coll_hit & ~flags[cles_pkg::BIT_COLLISION] & RX_EV.coll_pos_in_range) begin
         next_coll.valid = 1'b1;
         next_coll.pos = RX_EV.coll_pos;
      end
   end

   // ****************************************************************
   // Data path to the buffer and receive events
   // ****************************************************************
   always_comb begin
      // Byte with the protocol error and all later bytes up to the next command start or receive clear are dropped
      next_push = RX_EV.byte_valid & ~prot_hit & (rx_phase == cles_pkg::CLES_RX_RUN) &
                  ~BUF_FULL & ~flags[cles_pkg::BIT_OVERFLOW];
      next_push_data = RX_EV.byte_data;
      next_rx_irq = frame_ok;
      next_drop = short_hit;
      HOST_BUF_WR_ACCEPT = HOST_BUF_WR & ~BUF_FULL & ~flags[cles_pkg::BIT_OVERFLOW];
      RECEIVE_DECODER_EN = (rx_phase == cles_pkg::CLES_RX_RUN);
      SUMMARY_ERROR_IRQ = flags[cles_pkg::BIT_WR_MISUSE] | flags[cles_pkg::BIT_OVERFLOW] |
                          flags[cles_pkg::BIT_PROTOCOL] | flags[cles_pkg::BIT_EMPTY_TX] |
                          flags[cles_pkg::BIT_INTEGRITY];
   end

   // ****************************************************************
   // Register read port
   // ****************************************************************
   always_comb begin
      // Reads only sample, writes are ignored entirely
      next_rdata = REG_RDATA;
      if (REG_RD) begin
         case (REG_ADDR)
            cles_pkg::ADDR_ERROR_FLAGS: next_rdata = flags;
            cles_pkg::ADDR_STATE_STATUS: next_rdata = {cles_pkg::STATUS_RSVD_ZERO, state_code};
            default: next_rdata = cles_pkg::REG_ZERO;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rx_phase <= cles_pkg::CLES_RX_RUN;
         state_code <= cles_pkg::ST_IDLE;
         COLLISION_POSITION_REG <= '0;
         REG_RDATA <= cles_pkg::REG_ZERO;
         RX_PUSH <= 1'b0;
         RX_PUSH_DATA <= cles_pkg::REG_ZERO;
         RECEIVE_IRQ <= 1'b0;
         FRAME_DROP <= 1'b0;
      end else if (CE) begin
         rx_phase <= next_rx_phase;
         state_code <= next_state_code;
         COLLISION_POSITION_REG <= next_coll;
         REG_RDATA <= next_rdata;
         RX_PUSH <= next_push;
         RX_PUSH_DATA <= next_push_data;
         RECEIVE_IRQ <= next_rx_irq;
         FRAME_DROP <= next_drop;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RESETN);

   sequence s_prot_err;
      CE && prot_hit;
   endsequence

   sequence s_rx_stopped;
      !RECEIVE_DECODER_EN && flags[cles_pkg::BIT_PROTOCOL];
   endsequence

   // A clear is only checked when no event of that cycle sets the flag again
   sequence s_rx_clear_quiet;
      CE && rx_clear && !short_hit && !coll_hit && !prot_hit && !RX_EV.parity_err &&
      !RX_EV.crc_err;
   endsequence

   AST_NVM_FAIL: assert property (CE && NVM_CMD_DONE && NVM_CMD_FAIL
      |=> flags[cles_pkg::BIT_NVM_CMD])
      else $error("memory error flag not set");
   AST_MISUSE_SET: assert property (CE && HOST_BUF_WR && AUTH_CMD_ACTIVE
      |=> flags[cles_pkg::BIT_WR_MISUSE])
      else $error("write misuse flag not set");
   AST_MISUSE_CLR: assert property (CE && CL_CMD_START && !MULTI_FRAME_RECEIVE
      && !flag_set[cles_pkg::BIT_WR_MISUSE]
      |=> !flags[cles_pkg::BIT_WR_MISUSE])
      else $error("write misuse flag not cleared");
   AST_MISUSE_HOLD: assert property (CE && MULTI_FRAME_RECEIVE && !ERR_FLAGS_STORED
      && flags[cles_pkg::BIT_WR_MISUSE]
      |=> flags[cles_pkg::BIT_WR_MISUSE])
      else $error("write misuse flag cleared too early");
   AST_OVF_SET: assert property (CE && (HOST_BUF_WR || RX_EV.byte_valid) && BUF_FULL
      |-> !HOST_BUF_WR_ACCEPT ##1 (flags[cles_pkg::BIT_OVERFLOW] && !RX_PUSH))
      else $error("write to full buffer not refused");
   AST_OVF_DROP: assert property (flags[cles_pkg::BIT_OVERFLOW]
      |-> !HOST_BUF_WR_ACCEPT ##1 (!RX_PUSH || !$past(CE)))
      else $error("write accepted after overflow");
   AST_SHORT: assert property (CE && short_hit
      |=> flags[cles_pkg::BIT_SHORT_FRAME] && FRAME_DROP && !RECEIVE_IRQ)
      else $error("short frame not handled");
   AST_PROT_STOP: assert property (s_prot_err |=> s_rx_stopped ##0 !RX_PUSH)
      else $error("reception not stopped on protocol error");
   AST_STATE_CODE: assert property (REG_RDATA[7:3] == cles_pkg::STATUS_RSVD_ZERO
      || $past(REG_ADDR) != cles_pkg::ADDR_STATE_STATUS || !$past(REG_RD) || !$past(CE))
      else $error("reserved status bits not zero");
   AST_NO_UNUSED: assert property (state_code != cles_pkg::ST_UNUSED)
      else $error("unused state code shown");
   AST_SUMMARY: assert property (SUMMARY_ERROR_IRQ == |(flags & 8'h6B))
      else $error("summary error request wrong");
   AST_EOF_COLL: assert property (CE && RX_EV.coll && RX_EV.coll_in_eof
      && !rx_clear && !flags[cles_pkg::BIT_COLLISION] |=> !flags[cles_pkg::BIT_COLLISION])
      else $error("end-of-frame collision flagged");
   AST_EMPTY_TX: assert property (CE && TX_REQUEST && BUF_EMPTY
      |=> flags[cles_pkg::BIT_EMPTY_TX])
      else $error("empty transmit flag not set");
   AST_COLL_FIRST: assert property (CE && coll_hit && RX_EV.coll_pos_in_range
      && !rx_clear && !flags[cles_pkg::BIT_COLLISION] |=> flags[cles_pkg::BIT_COLLISION]
      && COLLISION_POSITION_REG.valid && COLLISION_POSITION_REG.pos == $past(RX_EV.coll_pos))
      else $error("first collision not recorded");
   AST_COLL_KEEP: assert property (CE && flags[cles_pkg::BIT_COLLISION] && !rx_clear
      |=> $stable(COLLISION_POSITION_REG))
      else $error("collision position overwritten");
   AST_RX_CLEAR: assert property (s_rx_clear_quiet
      |=> !flags[cles_pkg::BIT_SHORT_FRAME] && !flags[cles_pkg::BIT_COLLISION]
      && !flags[cles_pkg::BIT_PROTOCOL] && !flags[cles_pkg::BIT_INTEGRITY])
      else $error("receive flags not cleared");
   AST_INTEG_RUN: assert property (CE && (RX_EV.parity_err || RX_EV.crc_err)
      && !prot_hit && RECEIVE_DECODER_EN |=> flags[cles_pkg::BIT_INTEGRITY] && RECEIVE_DECODER_EN)
      else $error("integrity error stopped reception");
   AST_COLL_INTEG: assert property (CE && COLLISION_AS_ERROR && coll_hit
      |=> flags[cles_pkg::BIT_INTEGRITY])
      else $error("collision not counted as integrity error");

endmodule

// file: hw/cles_pkg.sv
package cles_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] ADDR_ERROR_FLAGS = 8'h0A;
   localparam logic [7:0] ADDR_STATE_STATUS = 8'h0B;
   localparam logic [7:0] REG_ZERO = 8'h00;
   localparam logic [4:0] STATUS_RSVD_ZERO = 5'h00;

   // ****************************************************************
   // Error flag bit positions
   // ****************************************************************
   localparam int BIT_NVM_CMD = 7;
   localparam int BIT_WR_MISUSE = 6;
   localparam int BIT_OVERFLOW = 5;
   localparam int BIT_SHORT_FRAME = 4;
   localparam int BIT_EMPTY_TX = 3;
   localparam int BIT_COLLISION = 2;
   localparam int BIT_PROTOCOL = 1;
   localparam int BIT_INTEGRITY = 0;
   localparam int NUM_FLAGS = 8;

   // ****************************************************************
   // Transceiver state codes
   // ****************************************************************
   localparam logic [2:0] ST_IDLE = 3'h0;
   localparam logic [2:0] ST_TX_WAIT = 3'h1;
   localparam logic [2:0] ST_TRANSMIT = 3'h3;
   localparam logic [2:0] ST_RX_WAIT = 3'h5;
   localparam logic [2:0] ST_WAIT_DATA = 3'h6;
   localparam logic [2:0] ST_RECEIVE = 3'h7;
   localparam logic [2:0] ST_UNUSED = 3'h4;

   // ****************************************************************
   // Frame length limits
   // ****************************************************************
   localparam logic [15:0] MIN_FRAME_BITS = 16'h0004;
   localparam logic [15:0] EMD_MIN_BYTES = 16'h0003;
   localparam logic [15:0] BITS_PER_BYTE = 16'h0008;
   localparam logic [15:0] EMD_MIN_BITS = 16'h0018;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      CLES_RX_RUN = 2'h1,
      CLES_RX_HALT = 2'h2
   } cles_rx_phase_e;

   typedef struct packed {
      logic sof_valid;
      logic frame_end;
      logic [15:0] bit_count;
      logic byte_valid;
      logic [7:0] byte_data;
      logic stop_bit_err;
      logic sof_err;
      logic byte_count_err;
      logic parity_err;
      logic crc_err;
      logic coll;
      logic coll_in_eof;
      logic coll_pos_in_range;
      logic [5:0] coll_pos;
   } cles_rx_ev_s;

   typedef struct packed {
      logic valid;
      logic [5:0] pos;
   } cles_coll_s;

endpackage

// file: hw/cles_flag.sv
module cles_flag (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // Flag control
   input wire logic set,
   input wire logic clr,
   output logic q
);

   logic next_q;

   // Set beats clear so an event in the clearing cycle is kept
   always_comb begin
      next_q = q;
      if (set) begin
         next_q = 1'b1;
      end else if (clr) begin
         next_q = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q <= 1'b0;
      end else if (ce) begin
         q <= next_q;
      end
   end

endmodule

// file: sim/cles_host_model.sv
module cles_host_model (
   // Clock
   input wire logic SYS_CLK,
   // Register port
   output logic [7:0] REG_ADDR,
   output logic REG_RD,
   output logic REG_WR,
   output logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // Host access
   // ****************************************************************
   initial begin
      REG_ADDR = 8'hFF;
      REG_RD = 1'b0;
      REG_WR = 1'b0;
      REG_WDATA = 8'h00;
   end

   // Released lines show the inverse, so a stale address never matches by luck
   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      REG_ADDR = addr;
      REG_RD = 1'b1;
      @(negedge SYS_CLK);
      REG_RD = 1'b0;
      REG_ADDR = ~addr;
      @(negedge SYS_CLK);
      data = REG_RDATA;
   endtask

   task automatic wr(input logic [7:0] addr, input logic [7:0] val);
      REG_ADDR = addr;
      REG_WDATA = val;
      REG_WR = 1'b1;
      @(negedge SYS_CLK);
      REG_WR = 1'b0;
      REG_ADDR = ~addr;
      REG_WDATA = ~val;
      @(negedge SYS_CLK);
   endtask
endmodule

// file: sim/contactless_error_status_regs_tb.sv
module contactless_error_status_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // Signals
   // ****************************************************************
   localparam logic [7:0] EF = 8'h0A;
   localparam logic [7:0] ST = 8'h0B;
   localparam logic [2:0] CODES [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
   logic SYS_CLK, RESETN, CE, REG_RD, REG_WR, cmd_start, is_rx, is_trx, auth, nvm_done;
   logic nvm_fail, crc_tx, tx_req, buf_wr, buf_full, buf_empty, flush, multi, stored;
   logic emd, coll_err, wr_accept, rx_push, rx_irq, drop, dec_en, sum_irq;
   logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, push_data;
   logic [2:0] state;
   cles_pkg::cles_rx_ev_s ev, e;
   cles_pkg::cles_coll_s coll_reg;
   int n_mismatch = 0;
   int samples_checked = 0;

   cles_regs u_dut (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .CE(CE), .REG_ADDR(REG_ADDR),
      .REG_RD(REG_RD), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
      .CL_CMD_START(cmd_start), .CMD_IS_RECEIVE(is_rx), .CMD_IS_TRANSCEIVE(is_trx),
      .AUTH_CMD_ACTIVE(auth), .NVM_CMD_DONE(nvm_done), .NVM_CMD_FAIL(nvm_fail),
      .TRANSCEIVER_STATE(state), .CRC_TX_PHASE(crc_tx), .TX_REQUEST(tx_req),
      .HOST_BUF_WR(buf_wr), .BUF_FULL(buf_full), .BUF_EMPTY(buf_empty), .BUF_FLUSH(flush),
      .MULTI_FRAME_RECEIVE(multi), .ERR_FLAGS_STORED(stored), .HOST_BUF_WR_ACCEPT(wr_accept),
      .RX_PUSH(rx_push), .RX_PUSH_DATA(push_data), .RX_EV(ev), .EMD_SUPPRESS_EN(emd),
      .COLLISION_AS_ERROR(coll_err), .RECEIVE_DECODER_EN(dec_en), .RECEIVE_IRQ(rx_irq),
      .FRAME_DROP(drop), .COLLISION_POSITION_REG(coll_reg), .SUMMARY_ERROR_IRQ(sum_irq));
   cles_host_model u_host (.SYS_CLK(SYS_CLK), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
      .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA));

   initial begin
      SYS_CLK = 1'b0;
      forever #2 SYS_CLK = ~SYS_CLK;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_reg(input logic [7:0] addr, input logic [7:0] exp, input string what);
      logic [7:0] got;
      u_host.rd(addr, got);
      chk(got, exp, what);
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge SYS_CLK);
      s = 1'b0;
   endtask

   // Pulse outputs stand one cycle, so they are looked at right after the taking edge
   task automatic rx(input cles_pkg::cles_rx_ev_s v, input logic [3:0] exp, input string what);
      ev = v;
      @(negedge SYS_CLK);
      ev = '0;
      chk({4'h0, rx_push, rx_irq, drop, dec_en}, {4'h0, exp}, what);
      if (exp[3]) begin
         chk(push_data, v.byte_data, what);
      end
      @(negedge SYS_CLK);
   endtask

   task automatic try_wr(input logic exp, input string what);
      buf_wr = 1'b1;
      #1;
      chk({7'h0, wr_accept}, {7'h0, exp}, what);
      @(negedge SYS_CLK);
      buf_wr = 1'b0;
   endtask

   function automatic cles_pkg::cles_rx_ev_s fr(input logic [15:0] bits);
      fr = '0;
      fr.sof_valid = 1'b1;
      fr.frame_end = 1'b1;
      fr.bit_count = bits;
   endfunction

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      {RESETN, cmd_start, is_rx, is_trx, auth, nvm_done, nvm_fail, crc_tx, tx_req} = '0;
      {buf_wr, buf_full, buf_empty, flush, multi, stored, emd, coll_err} = '0;
      CE = 1'b1;
      state = 3'h0;
      ev = '0;
      repeat (16) @(negedge SYS_CLK);
      RESETN = 1'b1;
      @(negedge SYS_CLK);
      chk_reg(EF, 8'h00, "flags reset");
      chk_reg(8'h0C, 8'h00, "unmapped");
      chk({7'h0, dec_en}, 8'h01, "decoder reset");
      foreach (CODES[i]) begin
         state = CODES[i];
         @(negedge SYS_CLK);
         chk_reg(ST, {5'h00, CODES[i]}, "state code");
      end
      state = 3'h4;
      u_host.wr(ST, 8'hFF);
      chk_reg(ST, 8'h07, "unused code or write");
      state = 3'h0;
      $display("test status done");
      nvm_fail = 1'b1;
      CE = 1'b0;
      pulse(nvm_done);
      CE = 1'b1;
      chk_reg(EF, 8'h00, "frozen");
      pulse(nvm_done);
      chk_reg(EF, 8'h80, "memory error");
      chk({7'h0, sum_irq}, 8'h00, "summary bit7");
      nvm_fail = 1'b0;
      pulse(nvm_done);
      chk_reg(EF, 8'h00, "memory ok");
      for (int i = 0; i < 3; i++) begin
         crc_tx = (i == 0);
         auth = (i == 1);
         state = (i == 2) ? 3'h5 : 3'h0;
         @(negedge SYS_CLK);
         pulse(buf_wr);
         crc_tx = 1'b0;
         auth = 1'b0;
         state = 3'h0;
         chk_reg(EF, 8'h40, "misuse");
         u_host.wr(EF, 8'h00);
         chk_reg(EF, 8'h40, "read or write side effect");
         chk({7'h0, sum_irq}, 8'h01, "summary misuse");
         pulse(cmd_start);
         chk_reg(EF, 8'h00, "start clear");
      end
      for (int m = 0; m < 2; m++) begin
         multi = (m == 1);
         crc_tx = 1'b1;
         pulse(buf_wr);
         crc_tx = 1'b0;
         if (m == 1) begin
            pulse(cmd_start);
            chk_reg(EF, 8'h40, "start keeps in multi");
         end
         pulse(stored);
         chk_reg(EF, (m == 1) ? 8'h00 : 8'h40, "store clear");
         pulse(cmd_start);
      end
      multi = 1'b0;
      $display("test misuse done");
      buf_full = 1'b1;
      try_wr(1'b0, "full refused");
      buf_full = 1'b0;
      chk_reg(EF, 8'h20, "overflow");
      chk({7'h0, sum_irq}, 8'h01, "summary overflow");
      try_wr(1'b0, "dropped after overflow");
      pulse(flush);
      try_wr(1'b1, "accepted");
      buf_empty = 1'b1;
      pulse(tx_req);
      buf_empty = 1'b0;
      chk_reg(EF, 8'h08, "empty tx");
      pulse(cmd_start);
      chk_reg(EF, 8'h00, "empty tx clear");
      $display("test buffer done");
      e = '0;
      e.byte_valid = 1'b1;
      e.byte_data = 8'hA5;
      rx(e, 4'b1001, "byte push");
      rx(fr(16'h0003), 4'b0011, "3 bits dropped");
      rx(fr(16'h0004), 4'b0101, "4 bits kept");
      chk_reg(EF, 8'h10, "short frame");
      emd = 1'b1;
      rx(fr(16'h0017), 4'b0011, "23 bits dropped");
      rx(fr(16'h0018), 4'b0101, "24 bits kept");
      emd = 1'b0;
      is_rx = 1'b1;
      pulse(cmd_start);
      chk_reg(EF, 8'h00, "receive clear");
      e = '0;
      e.coll = 1'b1;
      e.coll_pos_in_range = 1'b1;
      e.coll_pos = 6'h05;
      rx(e, 4'b0001, "collision");
      e.coll_pos = 6'h09;
      rx(e, 4'b0001, "second collision");
      chk({1'b0, coll_reg}, 8'h45, "first position");
      chk_reg(EF, 8'h04, "collision flag");
      is_trx = 1'b1;
      state = 3'h7;
      repeat (2) @(negedge SYS_CLK);
      state = 3'h6;
      repeat (2) @(negedge SYS_CLK);
      state = 3'h0;
      is_trx = 1'b0;
      chk_reg(EF, 8'h00, "wait-for-data clear");
      chk({1'b0, coll_reg}, 8'h00, "position clear");
      e.coll_in_eof = 1'b1;
      rx(e, 4'b0001, "eof collision");
      chk_reg(EF, 8'h00, "eof not flagged");
      e.coll_in_eof = 1'b0;
      coll_err = 1'b1;
      rx(e, 4'b0001, "collision as error");
      chk_reg(EF, 8'h05, "collision integrity");
      coll_err = 1'b0;
      pulse(cmd_start);
      e = '0;
      e.parity_err = 1'b1;
      e.crc_err = 1'b1;
      e.byte_valid = 1'b1;
      rx(e, 4'b1001, "integrity keeps receiving");
      chk_reg(EF, 8'h01, "integrity");
      for (int k = 0; k < 3; k++) begin
         pulse(cmd_start);
         e = '0;
         e.byte_valid = 1'b1;
         e.stop_bit_err = (k == 0);
         e.sof_err = (k == 1);
         e.byte_count_err = (k == 2);
         rx(e, 4'b0000, "protocol stop");
         chk_reg(EF, 8'h02, "protocol flag");
      end
      is_rx = 1'b0;
      pulse(cmd_start);
      chk_reg(EF, 8'h02, "plain start keeps");
      chk({7'h0, dec_en}, 8'h01, "decoder back");
      $display("test receive done");
      tally_and_finish();
   end

   initial begin
      repeat (5000) @(posedge SYS_CLK);
      n_mismatch++;
      tally_and_finish();
   end
endmodule
